// ---- vip_pkg.sv ----
// Functional notes
// - External clock rise samples pins while valid
// - Pin rates up to 81 MHz
// - Upper pins: raw10 bits, message start/end
// - Optional valid-independent message start/end sampling
// - Loopback bit selects video-out unit inputs
// - Loopback takes video-out external pin signals
// - Power down unless keep-awake bit set
// - Control write 0x00080000 or chip reset resets
// - Reset clears control, status, clock registers
// - Internal select 0: pin clock is input
// - Loopback with external clock uses video-out clock
// - Internal select 1: drive core clock divided
// - Full resolution splits Y, Cb, Cr streams
// - Resample off: chroma passes unmodified
// - Resample on: four-tap chroma filter over 16
// - Filtered chroma clamped to 01h..FFh
// - Filter mirrors samples at line edges
// - Four-bit mode field selects operation
// - Correct single, ignore double-error start codes
package vip_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CLK = 8'h08;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;
  localparam logic [31:0] CLK_RST = 32'h0000_0000;
  localparam logic [31:0] SOFT_RESET_WORD = 32'h0008_0000;
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_CAPTURE_ON = 4;
  localparam int CTL_CHROMA_RS = 5;
  localparam int CTL_LOOPBACK = 6;
  localparam int CTL_KEEP_AWAKE = 7;
  localparam int CTL_MSG_BYPASS = 8;
  localparam int STAT_X_LSB = 0;
  localparam int STAT_FIELD2 = 16;
  localparam int STAT_VBLANK = 17;
  localparam int STAT_CODE_ERR = 18;
  localparam int STAT_POWER_DOWN = 19;
  localparam int CLK_INTERNAL = 0;
  localparam int CLK_DIV_LSB = 8;
  localparam logic [7:0] DIV_MIN = 8'h02;
  // ----------------------------------------
  // Stream constants
  // ----------------------------------------
  localparam int PIN_RATE_MHZ = 81;
  localparam logic [7:0] PREAMBLE_HI = 8'hff;
  localparam logic [7:0] PREAMBLE_LO = 8'h00;
  localparam logic [13:0] TAP_NEAR = 14'h000d;
  localparam logic [13:0] TAP_FAR = 14'h0005;
  localparam int FILT_SHIFT = 4;
  localparam logic [7:0] CLAMP_MIN = 8'h01;
  localparam logic [7:0] CLAMP_MAX = 8'hff;
  typedef enum logic [3:0] {
    MODE_FULLRES = 4'h0, MODE_HALFRES = 4'h1, MODE_RAW8 = 4'h2,
    MODE_RAW10S = 4'h3, MODE_RAW10U = 4'h4, MODE_MESSAGE = 4'h5
  } mode_e;
endpackage

// ---- chroma_if.sv ----
`timescale 1ns/1ns
// Chroma sample path between parser and resampler
interface chroma_if;
  logic [7:0] smp;
  logic smp_vld;
  logic line_start;
  logic line_end;
  logic resample;
  logic [7:0] out;
  logic out_vld;
  modport src (output smp, smp_vld, line_start, line_end, resample, input out, out_vld);
  modport snk (input smp, smp_vld, line_start, line_end, resample, output out, out_vld);
endinterface

// ---- trs_decode.sv ----
`timescale 1ns/1ns
module trs_decode (
  // Status byte of a timing code
  input wire logic [7:0] code_i,
  // Corrected flags
  output logic f_o,
  output logic v_o,
  output logic h_o,
  output logic double_o
);
  logic [3:0] syn;
  // Syndrome of the protection bits
  always_comb begin
    syn = {code_i[3] ^ code_i[5] ^ code_i[4], code_i[2] ^ code_i[6] ^ code_i[4],
           code_i[1] ^ code_i[6] ^ code_i[5], code_i[0] ^ code_i[6] ^ code_i[5] ^ code_i[4]};
    f_o = code_i[6];
    v_o = code_i[5];
    h_o = code_i[4];
    double_o = 1'b0;
    case (syn)
      4'b0000, 4'b1000, 4'b0100, 4'b0010, 4'b0001: double_o = 1'b0;
      4'b0111: f_o = ~code_i[6];
      4'b1011: v_o = ~code_i[5];
      4'b1101: h_o = ~code_i[4];
      default: double_o = 1'b1;
    endcase
  end
endmodule

// ---- chroma_resampler.sv ----
`timescale 1ns/1ns
module chroma_resampler
  import vip_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Sample path
  chroma_if.snk ch
);
  logic [7:0] s0_q, s1_q, s2_q, out_q;
  logic [1:0] n_q, flush_q;
  logic vld_q;

  // Four-tap filter, full precision then clamp
  function automatic logic [7:0] filt(input logic [7:0] a, b, c, d);
    logic signed [13:0] acc;
    acc = $signed(14'(b) * TAP_NEAR + 14'(c) * TAP_FAR) - $signed(14'(a)) - $signed(14'(d));
    acc = acc >>> FILT_SHIFT;
    if (acc < $signed({6'h00, CLAMP_MIN})) filt = CLAMP_MIN;
    else if (acc > $signed({6'h00, CLAMP_MAX})) filt = CLAMP_MAX;
    else filt = acc[7:0];
  endfunction

  // Sample history and count along the line
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s0_q <= 8'h00;
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      n_q <= 2'h0;
      flush_q <= 2'h0;
    end else if (ch.line_start) begin
      n_q <= 2'h0;
      flush_q <= 2'h0;
    end else begin
      if (ch.smp_vld) begin
        s0_q <= ch.smp;
        s1_q <= s0_q;
        s2_q <= s1_q;
        n_q <= (n_q == 2'h3) ? n_q : n_q + 2'h1;
      end
      // Two tail outputs pending after line end
      if (ch.line_end && n_q[1]) flush_q <= 2'h2;
      else if (flush_q != 2'h0) flush_q <= flush_q - 2'h1;
    end
  end

  // Output, mirrored at both edges
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_q <= 8'h00;
      vld_q <= 1'b0;
    end else if (!ch.resample) begin
      out_q <= ch.smp;
      vld_q <= ch.smp_vld;
    end else if (ch.smp_vld && n_q == 2'h2) begin
      out_q <= filt(s0_q, s1_q, s0_q, ch.smp);
      vld_q <= 1'b1;
    end else if (ch.smp_vld && n_q == 2'h3) begin
      out_q <= filt(s2_q, s1_q, s0_q, ch.smp);
      vld_q <= 1'b1;
    end else if (flush_q == 2'h2) begin
      out_q <= filt(s2_q, s1_q, s0_q, s1_q);
      vld_q <= 1'b1;
    end else if (flush_q == 2'h1) begin
      out_q <= filt(s1_q, s0_q, s1_q, s2_q);
      vld_q <= 1'b1;
    end else begin
      vld_q <= 1'b0;
    end
  end

  assign ch.out = out_q;
  assign ch.out_vld = vld_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_clamp;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    vld_q && $past(ch.resample) |-> out_q >= CLAMP_MIN;
  endproperty
  a_clamp: assert property (p_clamp) else $error("filtered chroma below floor");
  property p_passthru;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    !ch.resample && ch.smp_vld |=> vld_q && out_q == $past(ch.smp);
  endproperty
  a_passthru: assert property (p_passthru) else $error("chroma not passed unmodified");
endmodule

// ---- video_input_port_frontend.sv ----
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module video_input_port_frontend
  import vip_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Video input pins
  input wire logic video_in_clock_pin_i,
  output logic video_in_clock_pin_o,
  output logic video_in_clock_pin_oe_b_o,
  input wire logic input_data_valid_pin_i,
  input wire logic [9:0] video_in_data_pins_i,
  // Video-out unit external pins, for loopback
  input wire logic video_out_unit_clock_i,
  input wire logic video_out_unit_dvalid_i,
  input wire logic [9:0] video_out_unit_data_i,
  // Power
  input wire logic global_power_down_i,
  output logic unit_power_down_o,
  // Planar streams
  output logic [7:0] luma_o,
  output logic luma_vld_o,
  output logic [7:0] cb_o,
  output logic cb_vld_o,
  output logic [7:0] cr_o,
  output logic cr_vld_o,
  // Raw and message stream
  output logic [9:0] raw_o,
  output logic raw_vld_o,
  output logic msg_start_o,
  output logic msg_end_o
);
  typedef enum logic [3:0] {
    ST_DATA = 4'b0001, ST_FF = 4'b0010, ST_Z1 = 4'b0100, ST_Z2 = 4'b1000
  } parse_e;

  logic [31:0] ctrl_q, clk_q, rdat_d;
  logic ack_q, wr_ok, soft_rst, sw_rst_q;
  logic [11:0] src_bus, sync1_q, sync2_q;
  logic clk_prev_q, ext_rise;
  logic [7:0] div_cnt_q, divisor;
  logic clk_out_q, int_rise_q, oe_b_q;
  logic internal, loopback, pd_q, samp, take;
  logic [9:0] data_s;
  logic [7:0] byte_q;
  logic byte_vld_q;
  parse_e state_q;
  logic dec_f, dec_v, dec_h, dec_dbl;
  logic active_q, field2_q, vblank_q, code_err_q;
  logic [1:0] phase_q;
  logic [10:0] cur_x_q;
  logic line_start_q, line_end_q, is_code;
  logic [7:0] luma_q;
  logic luma_vld_q, cap_on;
  logic [9:0] raw_q;
  logic raw_vld_q, msg_start_q, msg_end_q;
  mode_e mode;

  assign mode = mode_e'(ctrl_q[CTL_MODE_LSB +: 4]);
  assign internal = clk_q[CLK_INTERNAL];
  assign loopback = ctrl_q[CTL_LOOPBACK];
  assign cap_on = ctrl_q[CTL_CAPTURE_ON];

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // Write takes effect on the edge that the master sees ack
  assign wr_ok = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign soft_rst = wr_ok && wb_adr_i == OFS_CTRL && wb_sel_i == 4'hf
                    && wb_dat_i == SOFT_RESET_WORD;

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction

  // Acknowledge one cycle after the request, then drop
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q) wb_dat_o <= rdat_d;
    end
  end
  assign wb_ack_o = ack_q;

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdat_d = 32'h0000_0000;
    if (wb_adr_i == OFS_CTRL) begin
      rdat_d = ctrl_q;
    end else if (wb_adr_i == OFS_STAT) begin
      rdat_d[STAT_X_LSB +: 11] = cur_x_q;
      rdat_d[STAT_FIELD2] = field2_q;
      rdat_d[STAT_VBLANK] = vblank_q;
      rdat_d[STAT_CODE_ERR] = code_err_q;
      rdat_d[STAT_POWER_DOWN] = pd_q;
    end else if (wb_adr_i == OFS_CLK) begin
      rdat_d = clk_q;
    end
  end

  // Control and clock registers; software reset clears both
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= CTRL_RST;
      clk_q <= CLK_RST;
    end else if (soft_rst) begin
      ctrl_q <= CTRL_RST;
      clk_q <= CLK_RST;
    end else if (wr_ok && wb_adr_i == OFS_CTRL) begin
      ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
    end else if (wr_ok && wb_adr_i == OFS_CLK) begin
      clk_q <= merge(clk_q, wb_dat_i, wb_sel_i);
    end
  end

  // Pulse that clears the capture pipeline after a soft reset
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) sw_rst_q <= 1'b0;
    else sw_rst_q <= soft_rst;
  end

  // ----------------------------------------
  // Power down
  // ----------------------------------------
  // Keep-awake holds the unit running through chip power down
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) pd_q <= 1'b0;
    else pd_q <= global_power_down_i && !ctrl_q[CTL_KEEP_AWAKE];
  end
  assign unit_power_down_o = pd_q;

  // ----------------------------------------
  // Input mux and synchronisers
  // ----------------------------------------
  // Loopback picks the video-out pins, clock included
  assign src_bus = loopback
    ? {video_out_unit_clock_i, video_out_unit_dvalid_i, video_out_unit_data_i}
    : {video_in_clock_pin_i, input_data_valid_pin_i, video_in_data_pins_i};

  // Two stages before any logic looks at the pins
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= 12'h000;
      sync2_q <= 12'h000;
      clk_prev_q <= 1'b0;
    end else begin
      sync1_q <= src_bus;
      sync2_q <= sync1_q;
      clk_prev_q <= sync2_q[11];
    end
  end
  assign data_s = sync2_q[9:0];
  assign ext_rise = sync2_q[11] && !clk_prev_q;

  // ----------------------------------------
  // Internal clock generator
  // ----------------------------------------
  // Divisors below two clamp to two: a flop cannot emit the core clock
  assign divisor = (clk_q[CLK_DIV_LSB +: 8] < DIV_MIN) ? DIV_MIN : clk_q[CLK_DIV_LSB +: 8];

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt_q <= 8'h00;
      clk_out_q <= 1'b0;
      int_rise_q <= 1'b0;
      oe_b_q <= 1'b1;
    end else begin
      div_cnt_q <= (!internal || div_cnt_q >= divisor - 8'h01) ? 8'h00 : div_cnt_q + 8'h01;
      clk_out_q <= internal && div_cnt_q < (divisor >> 1);
      int_rise_q <= internal && div_cnt_q == 8'h00;
      oe_b_q <= !internal;
    end
  end
  assign video_in_clock_pin_o = clk_out_q;
  assign video_in_clock_pin_oe_b_o = oe_b_q;

  // ----------------------------------------
  // Sampling
  // ----------------------------------------
  // Only the selected edge samples; bytes only while valid is high, message markers in bypass without it
  assign samp = (internal ? int_rise_q : ext_rise) && !pd_q;
  assign take = samp && sync2_q[10];

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byte_q <= 8'h00;
      byte_vld_q <= 1'b0;
    end else begin
      if (take) byte_q <= data_s[7:0];
      byte_vld_q <= take && !sw_rst_q;
    end
  end

  // ----------------------------------------
  // Raw and message capture
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      raw_q <= 10'h000;
      raw_vld_q <= 1'b0;
      msg_start_q <= 1'b0;
      msg_end_q <= 1'b0;
    end else begin
      if (take) begin
        case (mode)
          MODE_RAW10S, MODE_RAW10U: raw_q <= data_s;
          default: raw_q <= {2'b00, data_s[7:0]};
        endcase
      end
      raw_vld_q <= take && cap_on && mode >= MODE_RAW8 && mode <= MODE_MESSAGE;
      // Bypass lets the markers ride without valid
      if (mode == MODE_MESSAGE && ctrl_q[CTL_MSG_BYPASS]) begin
        msg_start_q <= samp && data_s[8];
        msg_end_q <= samp && data_s[9];
      end else begin
        msg_start_q <= take && mode == MODE_MESSAGE && data_s[8];
        msg_end_q <= take && mode == MODE_MESSAGE && data_s[9];
      end
    end
  end

  // ----------------------------------------
  // Timing code parser
  // ----------------------------------------
  trs_decode u_trs (
    .code_i(byte_q),
    .f_o(dec_f),
    .v_o(dec_v),
    .h_o(dec_h),
    .double_o(dec_dbl)
  );

  assign is_code = byte_vld_q && state_q == ST_Z2;

  // Preamble tracker
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_DATA;
    end else if (sw_rst_q) begin
      state_q <= ST_DATA;
    end else if (byte_vld_q) begin
      case (state_q)
        ST_DATA: state_q <= (byte_q == PREAMBLE_HI) ? ST_FF : ST_DATA;
        ST_FF: state_q <= (byte_q == PREAMBLE_LO) ? ST_Z1
                        : (byte_q == PREAMBLE_HI) ? ST_FF : ST_DATA;
        ST_Z1: state_q <= (byte_q == PREAMBLE_LO) ? ST_Z2 : ST_DATA;
        ST_Z2: state_q <= ST_DATA;
        default: state_q <= ST_DATA;
      endcase
    end
  end

  // Line state; a start code with two errors is dropped,
  // an end code is taken even if damaged
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      active_q <= 1'b0;
      line_start_q <= 1'b0;
      line_end_q <= 1'b0;
      field2_q <= 1'b0;
      vblank_q <= 1'b0;
    end else if (sw_rst_q) begin
      active_q <= 1'b0;
      line_start_q <= 1'b0;
      line_end_q <= 1'b0;
      field2_q <= 1'b0;
      vblank_q <= 1'b0;
    end else begin
      line_start_q <= is_code && !dec_dbl && !dec_h;
      line_end_q <= is_code && (dec_dbl ? byte_q[4] : dec_h) && active_q;
      if (is_code && !dec_dbl) begin
        field2_q <= dec_f;
        vblank_q <= dec_v;
        active_q <= !dec_h;
      end else if (is_code && byte_q[4]) begin
        active_q <= 1'b0;
      end
    end
  end

  // Sticky damaged-code flag; set wins over write-one-clear
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) code_err_q <= 1'b0;
    else if (is_code && dec_dbl) code_err_q <= 1'b1;
    else if (soft_rst) code_err_q <= 1'b0;
    else if (wr_ok && wb_adr_i == OFS_STAT && wb_sel_i[2] && wb_dat_i[STAT_CODE_ERR])
      code_err_q <= 1'b0;
  end

  // ----------------------------------------
  // Component split
  // ----------------------------------------
  // Byte order after a start code: Cb, Y, Cr, Y
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_q <= 2'h0;
      cur_x_q <= 11'h000;
      luma_q <= 8'h00;
      luma_vld_q <= 1'b0;
    end else if (sw_rst_q) begin
      phase_q <= 2'h0;
      cur_x_q <= 11'h000;
      luma_vld_q <= 1'b0;
    end else if (line_start_q) begin
      phase_q <= 2'h0;
      cur_x_q <= 11'h7ff;
      luma_vld_q <= 1'b0;
    end else begin
      luma_vld_q <= 1'b0;
      if (byte_vld_q && state_q == ST_DATA && active_q && byte_q != PREAMBLE_HI) begin
        phase_q <= phase_q + 2'h1;
        if (phase_q[0]) begin
          cur_x_q <= cur_x_q + 11'h001;
          luma_q <= byte_q;
          luma_vld_q <= cap_on && mode == MODE_FULLRES;
        end
      end
    end
  end

  chroma_if cb_if ();
  chroma_if cr_if ();

  // Chroma to the two resamplers; gated here so the valid outputs stay bare flops
  assign cb_if.smp = byte_q;
  assign cr_if.smp = byte_q;
  assign cb_if.smp_vld = byte_vld_q && state_q == ST_DATA && active_q && cap_on
                         && mode == MODE_FULLRES && byte_q != PREAMBLE_HI && phase_q == 2'h0;
  assign cr_if.smp_vld = byte_vld_q && state_q == ST_DATA && active_q && cap_on
                         && mode == MODE_FULLRES && byte_q != PREAMBLE_HI && phase_q == 2'h2;
  // Soft reset also restarts the filter's sample count and tail flush
  assign cb_if.line_start = line_start_q || sw_rst_q;
  assign cr_if.line_start = line_start_q || sw_rst_q;
  assign cb_if.line_end = line_end_q;
  assign cr_if.line_end = line_end_q;
  assign cb_if.resample = ctrl_q[CTL_CHROMA_RS];
  assign cr_if.resample = ctrl_q[CTL_CHROMA_RS];

  chroma_resampler u_cb (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .ch(cb_if.snk)
  );

  chroma_resampler u_cr (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .ch(cr_if.snk)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign luma_o = luma_q;
  assign luma_vld_o = luma_vld_q;
  assign cb_o = cb_if.out;
  assign cb_vld_o = cb_if.out_vld;
  assign cr_o = cr_if.out;
  assign cr_vld_o = cr_if.out_vld;
  assign raw_o = raw_q;
  assign raw_vld_o = raw_vld_q;
  assign msg_start_o = msg_start_q;
  assign msg_end_o = msg_end_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_valid_gate;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    byte_vld_q |-> $past(sync2_q[10]) && !$past(pd_q);
  endproperty
  a_valid_gate: assert property (p_valid_gate) else $error("byte taken without valid");

  property p_loop_src;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    $past(loopback, 2) && $past(loopback) |->
      sync2_q == $past({video_out_unit_clock_i, video_out_unit_dvalid_i,
                        video_out_unit_data_i}, 2);
  endproperty
  a_loop_src: assert property (p_loop_src) else $error("loopback source not used");

  property p_soft_reset;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    soft_rst |=> ctrl_q == CTRL_RST && clk_q == CLK_RST ##1 sw_rst_q == 1'b0;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

  property p_pin_dir;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    internal |=> !video_in_clock_pin_oe_b_o;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("clock pin not driven");

  property p_div_edge;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    internal && $past(internal) && $rose(clk_out_q) |-> div_cnt_q == 8'h01;
  endproperty
  a_div_edge: assert property (p_div_edge) else $error("divided clock misaligned");

  property p_power;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    pd_q |=> !byte_vld_q;
  endproperty
  a_power: assert property (p_power) else $error("sampling while powered down");

  property p_double;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    is_code && dec_dbl && !sw_rst_q |=> !line_start_q ##0 code_err_q;
  endproperty
  a_double: assert property (p_double) else $error("damaged start code used");

  c_line: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    line_start_q ##[1:200] line_end_q);
  c_loop: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    loopback && byte_vld_q);
  c_filter: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ctrl_q[CTL_CHROMA_RS] && cb_vld_o);
endmodule

// ---- video_source.sv ----
`timescale 1ns/1ns
// Camera-side byte source; pin clock stands still between bytes
module video_source (
  // Core clock for pacing
  input wire logic core_clk_i,
  // Pins
  output logic pclk_o,
  output logic dvalid_o,
  output logic [9:0] data_o
);
  initial begin
    pclk_o = 1'b0;
    dvalid_o = 1'b0;
    data_o = 10'h000;
  end
  // ----------------------------------------
  // One byte: data stable around the rising edge
  // ----------------------------------------
  // Seven core cycles a pin period keeps it slower than core/4
  task automatic send(input logic v, input logic [9:0] d);
    @(posedge core_clk_i);
    {dvalid_o, data_o} <= {v, d};
    repeat (3) @(posedge core_clk_i);
    pclk_o <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    // Released bus shows inverse, never a stale match
    {pclk_o, dvalid_o, data_o} <= {2'b00, ~d};
  endtask
endmodule

// ---- video_input_port_frontend_bench.sv ----
`timescale 1ns/1ns
module video_input_port_frontend_bench;
  import vip_pkg::*;
  logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, gpd = 0, ck_p = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdo, q;
  logic ack, ck_o, oe_b, pd, rv, lv, cv, crv, ms, me, pclk, dv, lclk, ldv;
  logic [9:0] raw, raw_q, pdat, ldat;
  logic [7:0] y, cb, cr, y_q, cb_q, cr_q;
  int fail_count = 0, samples_checked = 0, cyc_n = 0, raw_n = 0, y_n = 0, ms_n = 0, me_n = 0;
  int rises = 0, i, j, n0;
  // Rows: control word, pin word, expected raw word; message mode keeps eight bits
  logic [31:0] row_ctl[4] = '{32'h12, 32'h13, 32'h14, 32'h15};
  logic [9:0] row_din[4] = '{10'h0a5, 10'h3c1, 10'h2f0, 10'h35a};
  logic [9:0] row_exp[4] = '{10'h0a5, 10'h3c1, 10'h2f0, 10'h05a};
  logic [9:0] fr[8] = '{10'h0ff, 10'h000, 10'h000, 10'h080, 10'h010, 10'h020, 10'h030, 10'h040};
  video_input_port_frontend video_input_port_frontend_i (.core_clk_i(clk), .rst_b_i(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack), .video_in_clock_pin_i(pclk),
    .video_in_clock_pin_o(ck_o), .video_in_clock_pin_oe_b_o(oe_b),
    .input_data_valid_pin_i(dv), .video_in_data_pins_i(pdat), .video_out_unit_clock_i(lclk),
    .video_out_unit_dvalid_i(ldv), .video_out_unit_data_i(ldat), .global_power_down_i(gpd),
    .unit_power_down_o(pd), .luma_o(y), .luma_vld_o(lv), .cb_o(cb), .cb_vld_o(cv), .cr_o(cr),
    .cr_vld_o(crv), .raw_o(raw), .raw_vld_o(rv), .msg_start_o(ms), .msg_end_o(me));
  video_source video_source_i (.core_clk_i(clk), .pclk_o(pclk), .dvalid_o(dv), .data_o(pdat));
  video_source loop_source_i (.core_clk_i(clk), .pclk_o(lclk), .dvalid_o(ldv), .data_o(ldat));
  initial begin
    forever #50 clk = ~clk;
  end
  // ----------------------------------------
  // Output monitor and timeout
  // ----------------------------------------
  // Pulses last one cycle, so latch them here
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    ck_p <= ck_o;
    rises <= rises + (ck_o === 1 && ck_p === 0);
    raw_n <= raw_n + (rv === 1);
    y_n <= y_n + (lv === 1);
    ms_n <= ms_n + (ms === 1);
    me_n <= me_n + (me === 1);
    if (rv === 1) raw_q <= raw;
    if (lv === 1) y_q <= y;
    if (cv === 1) cb_q <= cb;
    if (crv === 1) cr_q <= cr;
    if (cyc_n == 5000) begin
      fail_count++;
      conclude();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    // Only the bench timeout ends a wait for ack
    do @(posedge clk); while (ack !== 1);
    q = rdo;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic await_raw();
    for (j = 0; j < 15 && raw_n == n0; j++) @(posedge clk);
  endtask
  task automatic conclude();
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    // Three registers, then an unmapped word
    for (i = 0; i < 4; i++) begin
      wb(0, 8'(4 * i), 0);
      chk("reset read", 0, q);
    end
    // Raw modes and message mode, one byte each
    for (i = 0; i < 4; i++) begin
      wb(1, OFS_CTRL, row_ctl[i]);
      n0 = raw_n;
      video_source_i.send(1, row_din[i]);
      await_raw();
      chk("raw", row_exp[i], raw_q);
    end
    chk("msg start", 1, ms_n);
    chk("msg end", 1, me_n);
    // Low valid: byte must be dropped
    n0 = raw_n;
    video_source_i.send(0, 10'h0ff);
    repeat (15) @(posedge clk);
    chk("dropped", n0, raw_n);
    // Loopback takes the video-out pins
    wb(1, OFS_CTRL, 32'h52);
    n0 = raw_n;
    loop_source_i.send(1, 10'h03c);
    await_raw();
    chk("loopback", 10'h03c, raw_q);
    wb(1, OFS_CTRL, SOFT_RESET_WORD);
    wb(0, OFS_CTRL, 0);
    chk("soft reset", CTRL_RST, q);
    for (i = 0; i < 5; i++) video_source_i.send(0, 10'h000);
    wb(0, OFS_STAT, 0);
    chk("status reset", 0, q);
    // Start code with two bit errors: dropped, flagged
    for (i = 0; i < 4; i++) video_source_i.send(1, (i < 3) ? fr[i] : 10'h083);
    repeat (3) @(posedge clk);
    wb(0, OFS_STAT, 0);
    chk("code err", 32'h1 << STAT_CODE_ERR, q);
    // Keep-awake blocks power down
    wb(1, OFS_CTRL, 32'h80);
    gpd <= 1'b1;
    repeat (3) @(posedge clk);
    chk("awake", 0, pd);
    wb(1, OFS_CTRL, 0);
    repeat (3) @(posedge clk);
    chk("asleep", 1, pd);
    gpd <= 1'b0;
    // Internal clock, divisor 4
    wb(1, OFS_CLK, 32'h401);
    repeat (3) @(posedge clk);
    chk("drive", 0, oe_b);
    n0 = rises;
    repeat (16) @(posedge clk);
    chk("rises", n0 + 4, rises);
    wb(1, OFS_CLK, CLK_RST);
    repeat (3) @(posedge clk);
    chk("input", 1, oe_b);
    // Fullres line: start code, Cb Y Cr Y
    wb(1, OFS_CTRL, 32'h10);
    n0 = y_n;
    for (i = 0; i < 8; i++) video_source_i.send(1, fr[i]);
    repeat (15) @(posedge clk);
    chk("luma count", n0 + 2, y_n);
    chk("luma", 8'h40, y_q);
    chk("cb", 8'h10, cb_q);
    chk("cr", 8'h30, cr_q);
    // Interspersed chroma: flat zero chroma hits the floor
    wb(1, OFS_CTRL, 32'h30);
    for (i = 0; i < 16; i++) video_source_i.send(1, (i < 4) ? fr[i] : {4'h0, i[0], 5'h00});
    repeat (15) @(posedge clk);
    chk("cb filter", CLAMP_MIN, cb_q);
    chk("cr filter", CLAMP_MIN, cr_q);
    conclude();
  end
endmodule
